//--- core/fpec_mem.sv
`timescale 1ns/10ps
`default_nettype none
module fpec_mem #(
	parameter int AW = 13,
	parameter int DEPTH = 4608
) (
	// Clock.
	input wire logic clk,
	// Single port.
	input wire logic [AW-1:0] addr,
	input wire logic we,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);

	logic [7:0] mem [0:DEPTH-1];

	// The array leaves the factory erased.
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = 8'hFF;
		end
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule
`default_nettype wire

//--- core/fpec_top.sv
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
module fpec_top #(
	parameter logic [15:0] ARRAY_BASE_P = fpec_pkg::ARRAY_BASE,
	parameter int ARRAY_BYTES_P = fpec_pkg::ARRAY_BYTES
) (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RST_N,
	// Avalon-MM slave.
	input wire logic [fpec_pkg::AVS_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Analogue controls.
	output logic HIGH_VOLTAGE_ON,
	output logic CHARGE_PUMP_ON
);

	// The array must end at the top of the space and start on a page.
	generate
		if (ARRAY_BASE_P[5:0] != 6'h00 || 32'(ARRAY_BASE_P) + ARRAY_BYTES_P != 32'h10000
			|| ARRAY_BYTES_P > (1 << fpec_pkg::MEM_AW)) begin : g_bad_array
			$error("fpec_top: array geometry not supported");
		end
	endgenerate

	localparam int CW = fpec_pkg::MEM_AW + 1;

	fpec_pkg::fpec_bus_type bus_ff, nxt_bus;
	fpec_pkg::fpec_seq_type seq_ff, nxt_seq;
	fpec_pkg::fpec_ctrl_type ctrl_ff, nxt_ctrl;
	fpec_pkg::fpec_status_type sts_ff, nxt_sts;
	logic wait_ff, nxt_wait;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [7:0] bpr_ff, nxt_bpr;
	logic [15:0] latch_ff, nxt_latch;
	logic [15:0] walk_ff, nxt_walk;
	logic [CW-1:0] left_ff, nxt_left;
	logic [fpec_pkg::RCV_W-1:0] rcv_ff, nxt_rcv;
	logic pump_ff, nxt_pump;

	logic [fpec_pkg::MEM_AW-1:0] mem_addr;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic [15:0] mem_flash;

	logic req;
	logic is_reg;
	logic [2:0] reg_idx;
	logic [15:0] faddr;
	logic in_arr;
	logic be0;
	logic hv_block;
	logic hv_erase;
	logic read_block;
	fpec_pkg::fpec_ctrl_type wr_ctrl;

	assign req = AVS_READ | AVS_WRITE;
	assign is_reg = AVS_ADDRESS[fpec_pkg::REG_SEL_BIT];
	assign reg_idx = AVS_ADDRESS[fpec_pkg::REG_IDX_LSB +: 3];
	assign faddr = AVS_ADDRESS[fpec_pkg::REG_IDX_LSB +: 16];
	assign in_arr = !is_reg && faddr >= ARRAY_BASE_P;
	assign be0 = AVS_BYTEENABLE[0];
	assign wr_ctrl = AVS_WRITEDATA[3:0];
	// Array reads are refused (read as zero) while the cells see high voltage and until they settle.
	assign read_block = ctrl_ff.high_voltage_enable || rcv_ff != '0;

	// Mode as it stands after the current control write, taken from the bus to avoid a loop.
	assign hv_erase = (wr_ctrl.program_select && wr_ctrl.erase) ? ctrl_ff.erase : wr_ctrl.erase;

	// Mass erase needs a clean protect byte; page targets are checked on their base, program targets on the latched address.
	always_comb begin
		if (hv_erase && wr_ctrl.mass) begin
			hv_block = bpr_ff != fpec_pkg::PROTECT_NONE;
		end else if (hv_erase) begin
			hv_block = fpec_pkg::fpec_protected({latch_ff[15:fpec_pkg::PAGE_LSB], 6'h00}, bpr_ff);
		end else begin
			hv_block = fpec_pkg::fpec_protected(latch_ff, bpr_ff);
		end
	end

	always_comb begin
		nxt_bus = bus_ff;
		nxt_seq = seq_ff;
		nxt_ctrl = ctrl_ff;
		nxt_sts = sts_ff;
		nxt_wait = 1'b1;
		nxt_rdata = rdata_ff;
		nxt_bpr = bpr_ff;
		nxt_latch = latch_ff;
		nxt_walk = walk_ff;
		nxt_left = left_ff;
		nxt_rcv = (rcv_ff != '0) ? rcv_ff - 1'b1 : rcv_ff;
		mem_flash = faddr;
		mem_we = 1'b0;
		mem_wdata = fpec_pkg::ERASED_BYTE;
		case (bus_ff)
			fpec_pkg::BUS_BOOT: begin
				mem_flash = fpec_pkg::PROTECT_ADDR;
				nxt_bus = fpec_pkg::BUS_BOOT_LOAD;
			end
			fpec_pkg::BUS_BOOT_LOAD: begin
				nxt_bpr = mem_rdata;
				nxt_bus = fpec_pkg::BUS_IDLE;
			end
			fpec_pkg::BUS_IDLE: begin
				if (req) begin
					nxt_bus = fpec_pkg::BUS_FETCH;
				end
			end
			fpec_pkg::BUS_FETCH: begin
				nxt_rdata = 32'h0000_0000;
				if (AVS_READ) begin
					if (is_reg) begin
						case (reg_idx)
							fpec_pkg::REG_CTRL: nxt_rdata[3:0] = ctrl_ff;
							fpec_pkg::REG_PROTECT: nxt_rdata[7:0] = bpr_ff;
							fpec_pkg::REG_STATUS: nxt_rdata[3:0] = sts_ff;
							default: nxt_rdata = 32'h0000_0000;
						endcase
					end else if (in_arr && !read_block) begin
						nxt_rdata[7:0] = mem_rdata;
					end
				end
				nxt_wait = 1'b0;
				nxt_bus = fpec_pkg::BUS_ACK;
			end
			fpec_pkg::BUS_ACK: begin
				nxt_bus = fpec_pkg::BUS_IDLE;
				if (AVS_READ && (is_reg && reg_idx == fpec_pkg::REG_PROTECT
					|| !is_reg && faddr == fpec_pkg::PROTECT_ADDR)) begin
					if (seq_ff == fpec_pkg::SEQ_ARMED) begin
						nxt_seq = fpec_pkg::SEQ_PROT_READ;
					end
				end
				if (AVS_WRITE && be0 && is_reg && reg_idx == fpec_pkg::REG_CTRL) begin
					nxt_ctrl.mass = wr_ctrl.mass;
					if (!(wr_ctrl.program_select && wr_ctrl.erase)) begin
						nxt_ctrl.program_select = wr_ctrl.program_select;
						nxt_ctrl.erase = wr_ctrl.erase;
					end
					if ((nxt_ctrl.program_select && !ctrl_ff.program_select) || (nxt_ctrl.erase && !ctrl_ff.erase)) begin
						nxt_seq = fpec_pkg::SEQ_ARMED;
					end
					if (!nxt_ctrl.program_select && !nxt_ctrl.erase) begin
						nxt_seq = fpec_pkg::SEQ_IDLE;
					end
					if (!wr_ctrl.high_voltage_enable) begin
						nxt_ctrl.high_voltage_enable = 1'b0;
						if (ctrl_ff.high_voltage_enable) begin
							nxt_rcv = fpec_pkg::RCV_W'(fpec_pkg::RCV_CYCLES);
							if (nxt_ctrl.program_select || nxt_ctrl.erase) begin
								nxt_seq = fpec_pkg::SEQ_LATCHED;
							end
						end
					end else if (!ctrl_ff.high_voltage_enable) begin
						if ((nxt_ctrl.program_select || nxt_ctrl.erase) && seq_ff == fpec_pkg::SEQ_LATCHED
							&& nxt_seq == fpec_pkg::SEQ_LATCHED && !hv_block) begin
							nxt_ctrl.high_voltage_enable = 1'b1;
							nxt_seq = fpec_pkg::SEQ_HV;
							if (nxt_ctrl.erase) begin
								if (nxt_ctrl.mass) begin
									nxt_walk = ARRAY_BASE_P;
									nxt_left = CW'(ARRAY_BYTES_P);
								end else begin
									// The page below the vector page shares its 64 bytes with the trim byte.
									nxt_walk = {latch_ff[15:fpec_pkg::PAGE_LSB], 6'h00};
									nxt_left = CW'(fpec_pkg::PAGE_BYTES);
								end
							end
						end else begin
							nxt_sts.hv_refused = 1'b1;
						end
					end
				end
				if (AVS_WRITE && be0 && is_reg && reg_idx == fpec_pkg::REG_STATUS) begin
					nxt_sts.hv_refused = sts_ff.hv_refused & ~AVS_WRITEDATA[3];
					nxt_sts.read_refused = sts_ff.read_refused & ~AVS_WRITEDATA[2];
				end
				if (AVS_WRITE && be0 && in_arr) begin
					if (seq_ff == fpec_pkg::SEQ_PROT_READ) begin
						nxt_latch = faddr;
						nxt_seq = fpec_pkg::SEQ_LATCHED;
					end else if (seq_ff == fpec_pkg::SEQ_HV && ctrl_ff.program_select
						&& faddr[15:fpec_pkg::ROW_LSB] == latch_ff[15:fpec_pkg::ROW_LSB]
						&& !fpec_pkg::fpec_protected(faddr, bpr_ff)) begin
						mem_we = 1'b1;
						mem_wdata = mem_rdata & AVS_WRITEDATA[7:0];
					end
				end
			end
			default: begin
				nxt_bus = fpec_pkg::BUS_IDLE;
			end
		endcase
		if (bus_ff == fpec_pkg::BUS_FETCH && AVS_READ && in_arr && read_block) begin
			nxt_sts.read_refused = 1'b1;
		end
		// Erase clears one byte a cycle, which stays far inside any erase time.
		if (left_ff != '0) begin
			if (ctrl_ff.high_voltage_enable && ctrl_ff.erase) begin
				mem_flash = walk_ff;
				mem_we = 1'b1;
				mem_wdata = fpec_pkg::ERASED_BYTE;
				nxt_walk = walk_ff + 16'h0001;
				nxt_left = left_ff - 1'b1;
			end else begin
				nxt_left = '0;
			end
		end
		if (mem_we && mem_flash == fpec_pkg::PROTECT_ADDR) begin
			nxt_bpr = mem_wdata;
		end
		nxt_sts.hv_on = nxt_ctrl.high_voltage_enable;
		nxt_sts.erase_busy = nxt_left != '0;
		nxt_pump = nxt_ctrl.high_voltage_enable;
	end

	assign mem_addr = fpec_pkg::MEM_AW'(mem_flash - ARRAY_BASE_P);

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			bus_ff <= fpec_pkg::BUS_BOOT;
			seq_ff <= fpec_pkg::SEQ_IDLE;
			ctrl_ff <= fpec_pkg::CTRL_RESET;
			sts_ff <= '0;
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
			bpr_ff <= fpec_pkg::PROTECT_NONE;
			latch_ff <= 16'h0000;
			walk_ff <= 16'h0000;
			left_ff <= '0;
			rcv_ff <= '0;
			pump_ff <= 1'b0;
		end else begin
			bus_ff <= nxt_bus;
			seq_ff <= nxt_seq;
			ctrl_ff <= nxt_ctrl;
			sts_ff <= nxt_sts;
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			bpr_ff <= nxt_bpr;
			latch_ff <= nxt_latch;
			walk_ff <= nxt_walk;
			left_ff <= nxt_left;
			rcv_ff <= nxt_rcv;
			pump_ff <= nxt_pump;
		end
	end

	fpec_mem #(
		.AW(fpec_pkg::MEM_AW),
		.DEPTH(ARRAY_BYTES_P)
	) u_mem (
		.clk(CLOCK),
		.addr(mem_addr),
		.we(mem_we),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	assign AVS_READDATA = rdata_ff;
	assign AVS_WAITREQUEST = wait_ff;
	assign HIGH_VOLTAGE_ON = ctrl_ff.high_voltage_enable;
	assign CHARGE_PUMP_ON = pump_ff;

endmodule
`default_nettype wire

//--- inc/fpec_pkg.sv
// Operation
// - Erase unit 64 bytes, program row 32 bytes.
// - Erased cell reads one, programmed reads zero.
// - High voltage only after full armed sequence.
// - High voltage bit drives pump and array.
// - Mass select widens erase to whole array.
// - Erase and program select never both set.
// - Pages are aligned 64 bytes; vectors one page.
// - Erase page taken from dummy write address.
// - Mass erase refused while anything is protected.
// - Program rows are aligned 32-byte blocks.
// - Program select enables address and data capture.
// - Protected target blocks high voltage enable.
// - Vector page or mass erase clears trim; code clears it by mass erase or by erasing the page at FF80.
// - Protect byte gives start address bits 13:6.
// - Protected range and protect byte are immutable.
package fpec_pkg;

	localparam int AVS_AW = 19;
	localparam int REG_SEL_BIT = 18;
	localparam int REG_IDX_LSB = 2;
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_PROTECT = 3'h1;
	localparam logic [2:0] REG_STATUS = 3'h2;

	localparam logic [15:0] ARRAY_BASE = 16'hEE00;
	localparam int ARRAY_BYTES = 4608;
	localparam int MEM_AW = 13;
	localparam logic [15:0] PROTECT_ADDR = 16'hFFBE;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] PROTECT_NONE = 8'hFF;
	localparam logic [1:0] PROTECT_TOP = 2'h3;
	localparam int PAGE_LSB = 6;
	localparam int ROW_LSB = 5;
	localparam logic [13:0] PAGE_BYTES = 14'h0040;

	localparam int CLK_FREQ_MHZ = 250;
	localparam int RECOVERY_NS = 1000;
	localparam int RCV_CYCLES = (RECOVERY_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int RCV_W = 9;

	typedef struct packed {
		logic high_voltage_enable;
		logic mass;
		logic erase;
		logic program_select;
	} fpec_ctrl_type;

	localparam fpec_ctrl_type CTRL_RESET = 4'h0;

	typedef struct packed {
		logic hv_refused;
		logic read_refused;
		logic erase_busy;
		logic hv_on;
	} fpec_status_type;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_ARMED,
		SEQ_PROT_READ,
		SEQ_LATCHED,
		SEQ_HV
	} fpec_seq_type;

	typedef enum logic [2:0] {
		BUS_BOOT,
		BUS_BOOT_LOAD,
		BUS_IDLE,
		BUS_FETCH,
		BUS_ACK
	} fpec_bus_type;

	function automatic logic fpec_protected(input logic [15:0] addr, input logic [7:0] bpr);
		fpec_protected = (bpr != PROTECT_NONE) && (addr >= {PROTECT_TOP, bpr, 6'h00});
	endfunction

	function automatic logic fpec_in_array(input logic [15:0] addr);
		fpec_in_array = (addr >= ARRAY_BASE);
	endfunction

endpackage

//--- tb/fpec_host.sv
`timescale 1ns/10ps
`default_nettype none
module fpec_host (
	// Clock.
	input wire logic clk,
	// Bus master.
	output logic [fpec_pkg::AVS_AW-1:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	output logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest
);
	initial begin
		address = 19'h00000;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		byteenable = 4'hF;
	end
	// Holds the request until accepted, then lets one edge pass before the next.
	task automatic bus(input logic we, input logic [18:0] a, input logic [31:0] d,
		output logic [31:0] q);
		address <= a;
		writedata <= d;
		read <= !we;
		write <= we;
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

//--- tb/fpec_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module fpec_top_chk (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RST_N,
	// Register bus.
	input wire logic [fpec_pkg::AVS_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// Analogue controls.
	input wire logic HIGH_VOLTAGE_ON,
	input wire logic CHARGE_PUMP_ON
);
	logic acc_rd;
	logic acc_arr;
	logic hv_wr;
	logic [7:0] quiet_ff;
	logic [7:0] nxt_quiet;
	assign acc_rd = AVS_READ && !AVS_WAITREQUEST;
	assign acc_arr = acc_rd && !AVS_ADDRESS[18];
	assign hv_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 19'h40000
		&& AVS_WRITEDATA[3] && AVS_BYTEENABLE[0];
	// Saturates so a long idle spell never wraps back into the refusal window.
	always_comb begin
		nxt_quiet = quiet_ff;
		if (HIGH_VOLTAGE_ON)
			nxt_quiet = 8'h00;
		else if (quiet_ff != 8'hFF)
			nxt_quiet = quiet_ff + 8'h01;
	end
	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			quiet_ff <= 8'hFF;
		else
			quiet_ff <= nxt_quiet;
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	sequence s_answer;
		##[1:6] !AVS_WAITREQUEST;
	endsequence
	a_pump_hv:
	assert property (CHARGE_PUMP_ON == HIGH_VOLTAGE_ON) else $error("pump and voltage differ");
	a_hv_cause:
	assert property ($rose(HIGH_VOLTAGE_ON) |-> $past(hv_wr) || $past(hv_wr, 2))
		else $error("voltage rose without enable write");
	a_read_refused:
	assert property (acc_arr && (HIGH_VOLTAGE_ON || quiet_ff < 8'hF0) |-> AVS_READDATA == 32'h0)
		else $error("array read served during voltage");
	a_ctrl_interlock:
	assert property (acc_rd && AVS_ADDRESS == 19'h40000 |-> !(AVS_READDATA[0] && AVS_READDATA[1]))
		else $error("erase and program both set");
	a_wait_single:
	assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("accept longer than one cycle");
	a_req_answered:
	assert property ($rose(AVS_READ || AVS_WRITE) |-> s_answer) else $error("request not answered");
	a_answer_req:
	assert property (!AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE) else $error("accept without request");
	a_unmapped_zero:
	assert property (acc_rd && AVS_ADDRESS[18] && AVS_ADDRESS[4:2] > 3'h2 |-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind fpec_top fpec_top_chk i_fpec_top_chk (.CLOCK(CLOCK), .RST_N(RST_N),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.HIGH_VOLTAGE_ON(HIGH_VOLTAGE_ON), .CHARGE_PUMP_ON(CHARGE_PUMP_ON));
`default_nettype wire

//--- tb/test_flash_program_erase_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_flash_program_erase_control;
	logic clock;
	logic rst_n;
	logic [18:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [3:0] byteenable;
	logic [31:0] readdata;
	logic waitrequest;
	logic hv;
	logic pump;
	int bad_count;
	int cmp_count;
	localparam logic [18:0] CTRL = 19'h40000;
	localparam logic [18:0] PROT = 19'h40004;
	fpec_top i_fpec_top (.CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(address), .AVS_READ(read),
		.AVS_WRITE(write), .AVS_WRITEDATA(writedata), .AVS_BYTEENABLE(byteenable),
		.AVS_READDATA(readdata), .AVS_WAITREQUEST(waitrequest), .HIGH_VOLTAGE_ON(hv),
		.CHARGE_PUMP_ON(pump));
	fpec_host i_fpec_host (.clk(clock), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [18:0] fa(input logic [15:0] a);
		return {1'b0, a, 2'b00};
	endfunction
	task automatic wr(input logic [18:0] a, input logic [7:0] d);
		logic [31:0] q;
		i_fpec_host.bus(1'b1, a, {24'h000000, d}, q);
	endtask
	task automatic rd(input logic [18:0] a, input logic [31:0] exp);
		logic [31:0] q;
		i_fpec_host.bus(1'b0, a, 32'h00000000, q);
		chk(q, exp);
	endtask
	task automatic reset_dut();
		rst_n <= 1'b0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
	endtask
	// Arm, read protection, latch target, raise voltage, then wind down in order.
	task automatic op(input logic [2:0] m, input logic [15:0] a, input logic [7:0] d,
		input logic hv_exp, input int h);
		logic [31:0] q;
		wr(CTRL, {5'h00, m});
		i_fpec_host.bus(1'b0, PROT, 32'h00000000, q);
		wr(fa(a), 8'hFF);
		repeat (8) @(posedge clock);
		wr(CTRL, {5'h01, m});
		repeat (2) @(posedge clock);
		chk({31'h00000000, hv}, {31'h00000000, hv_exp});
		if (hv_exp)
			rd(fa(a), 32'h0);
		if (m == 3'h1)
			wr(fa(a), d);
		repeat (h) @(posedge clock);
		wr(CTRL, 8'h08);
		wr(CTRL, 8'h00);
		if (hv_exp)
			rd(fa(a), 32'h0);
		repeat (260) @(posedge clock);
	endtask
	initial begin
		bad_count = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		reset_dut();
		rd(CTRL, 32'h0);
		rd(PROT, 32'hFF);
		rd(fa(16'hF000), 32'hFF);
		rd(19'h4000C, 32'h0);
		wr(CTRL, 8'h03);
		rd(CTRL, 32'h0);
		$display("test reset and interlock done");
		op(3'h1, 16'hF000, 8'hA5, 1'b1, 8);
		op(3'h1, 16'hF040, 8'h3C, 1'b1, 8);
		op(3'h1, 16'hFFC0, 8'h12, 1'b1, 8);
		wr(fa(16'hF021), 8'h00);
		rd(fa(16'hF000), 32'hA5);
		rd(fa(16'hF021), 32'hFF);
		$display("test program done");
		op(3'h2, 16'hF010, 8'hFF, 1'b1, 80);
		rd(fa(16'hF000), 32'hFF);
		rd(fa(16'hF040), 32'h3C);
		rd(fa(16'hFFC0), 32'h12);
		op(3'h6, 16'hEE00, 8'hFF, 1'b1, 4700);
		rd(fa(16'hF040), 32'hFF);
		rd(fa(16'hFFC0), 32'hFF);
		$display("test erase done");
		op(3'h1, 16'hFFBE, 8'hFE, 1'b1, 8);
		reset_dut();
		rd(PROT, 32'hFE);
		op(3'h6, 16'hEE00, 8'hFF, 1'b0, 8);
		rd(19'h40008, 32'h8);
		op(3'h2, 16'hFFC0, 8'hFF, 1'b0, 8);
		op(3'h1, 16'hFF80, 8'h00, 1'b0, 8);
		op(3'h1, 16'hF000, 8'h0F, 1'b1, 8);
		rd(fa(16'hF000), 32'h0F);
		rd(fa(16'hFF80), 32'hFF);
		$display("test protection done");
		final_report();
	end
	initial begin
		#400000;
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
